// file: rtl/power_mode_params.svh
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH

// debug command classes on the command port
`define CMD_CLASS_MEM 3'h0
`define CMD_CLASS_MEM_STATUS 3'h1
`define CMD_CLASS_DBG_REG 3'h2
`define CMD_CLASS_ENTER_HALT 3'h3
`define CMD_CLASS_CPU_REG 3'h4
`define CMD_CLASS_TRACE 3'h5
`define CMD_CLASS_RESUME 3'h6

// answer codes on the debug answer port
`define ANS_ACCEPT 2'h0
`define ANS_STOP_WAIT_ERROR 2'h1
`define ANS_REFUSED 2'h2

// wake source count and bit positions
`define WAKE_SOURCES 16
`define WAKE_BIT_IRQ_PIN 0
`define WAKE_BIT_RTC 12

// pin latch width default
`define PIN_COUNT 8
`define PIN_RESET_VALUE 8'h00

`endif

// file: rtl/power_mode_pkg.sv
package power_mode_pkg;

  // operating mode of the device
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_HALT = 3'b001,
    MODE_WAIT = 3'b010,
    MODE_LIGHT_STOP = 3'b011,
    MODE_DEEP_STOP = 3'b100
  } op_mode_t;

  // outcome of a stop instruction
  typedef enum logic [1:0] {
    STOP_ILLEGAL = 2'b00,
    STOP_LIGHT = 2'b01,
    STOP_LIGHT_REG = 2'b10,
    STOP_DEEP = 2'b11
  } stop_sel_t;

endpackage : power_mode_pkg

// file: rtl/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // first stage is read only by the second
  always_comb begin
    state_next.first = async_in;
    state_next.second = state_reg.first;
  end

  // no reset: the stages keep flushing while reset is held, so the pin
  // level is already valid at the first edge after release
  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  assign sync_out = state_reg.second;

endmodule : level_sync
`default_nettype wire

// file: rtl/stop_select.sv
`timescale 1ns/1ps
`default_nettype none
module stop_select
  import power_mode_pkg::*;
(
  input wire logic stop_enable_bit,
  input wire logic debug_mode_enable_bit,
  input wire logic voltage_monitor_enable,
  input wire logic voltage_monitor_stop_enable,
  input wire logic partial_powerdown_select,
  output stop_sel_t stop_choice
);

  // stop depth table
  always_comb begin
    if (!stop_enable_bit) begin
      stop_choice = STOP_ILLEGAL;
    end else if (debug_mode_enable_bit) begin
      stop_choice = STOP_LIGHT;
    end else if (voltage_monitor_enable && voltage_monitor_stop_enable) begin
      stop_choice = STOP_LIGHT_REG;
    end else if (partial_powerdown_select) begin
      stop_choice = STOP_DEEP;
    end else begin
      stop_choice = STOP_LIGHT;
    end
  end

endmodule : stop_select
`default_nettype wire

// file: rtl/power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"
// What this block does
// - debug pin high at reset release selects run
// - debug pin low at reset release selects halt
// - halt command, instruction or breakpoints enter halt
// - halt keeps cpu suspended awaiting debug commands
// - non-intrusive commands accepted in run and halt
// - cpu register, trace, resume only in halt
// - wait stops cpu clock, clears interrupt mask
// - interrupt ends wait, cpu stacks into service
// - wait accepts halt commands only, status gets error answer
// - stop with stop disabled causes illegal reset
// - stop with debug enabled enters light stop
// - both monitor bits give light stop, regulator on
// - otherwise select bit picks light or deep
// - light stop holds registers, ram and pins
// - listed pins and interrupts leave light stop
// - reset pin resets, interrupt fetches its vector
// - both monitor bits keep regulator on in stop
// - debug enabled keeps debug clocks and regulation
// - halt command in debug stop wakes into halt
// - deep stop powers off all but ram, latches pins
// - deep stop left by reset pin or counter
// - deep stop wake acts as power-on reset
// - flag and latches stay until acknowledge written
// - acknowledge releases latches to live pin control
module power_mode_controller
  import power_mode_pkg::*;
#(
  parameter int PINS = `PIN_COUNT,
  parameter int WAKES = `WAKE_SOURCES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mode_select_debug_pin,
  input wire logic reset_pin_n,
  input wire logic [WAKES-1:0] wake_irq,
  input wire logic rtc_wake_enable,
  input wire logic stop_enable_bit,
  input wire logic debug_mode_enable_bit,
  input wire logic voltage_monitor_enable,
  input wire logic voltage_monitor_stop_enable,
  input wire logic partial_powerdown_select,
  input wire logic partial_powerdown_acknowledge,
  input wire logic exec_wait,
  input wire logic exec_stop,
  input wire logic exec_halt_to_debug_instruction,
  input wire logic serial_debug_controller_break,
  input wire logic trace_module_break,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_class,
  input wire logic [PINS-1:0] pin_ctrl_live,
  output op_mode_t mode,
  output logic cpu_clock_en,
  output logic cpu_run,
  output logic clear_interrupt_mask,
  output logic start_stacking,
  output logic illegal_opcode_reset,
  output logic por_reset,
  output logic fetch_reset_vector,
  output logic debug_clock_en,
  output logic regulator_active,
  output logic core_power_en,
  output logic low_voltage_reset_en,
  output logic partial_powerdown_flag,
  output logic [PINS-1:0] pin_ctrl_out,
  output logic ans_valid,
  output logic [1:0] ans_code
);

  typedef struct packed {
    op_mode_t mode;
    logic boot_done;
    logic stop_reg_keep;
    logic cpu_clock_en;
    logic cpu_run;
    logic clear_imask;
    logic stacking;
    logic illegal_rst;
    logic por_rst;
    logic fetch_rv;
    logic debug_clk;
    logic regulator;
    logic core_pwr;
    logic lvr_en;
    logic ppd_flag;
    logic latched;
    logic [PINS-1:0] pins_held;
    logic [PINS-1:0] pins_out;
    logic ans_valid;
    logic [1:0] ans_code;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;
  stop_sel_t stop_choice;
  logic ms_sync;
  logic rst_pin_sync_n;
  logic [WAKES-1:0] wake_sync;
  logic any_wake;
  logic deep_wake;
  logic halt_cmd;
  logic halt_event;

  // pins from outside pass two flops
  level_sync #(.WIDTH(WAKES + 2)) pin_sync (
    .clock(clock),
    .async_in({wake_irq, reset_pin_n, mode_select_debug_pin}),
    .sync_out({wake_sync, rst_pin_sync_n, ms_sync})
  );

  stop_select stop_sel (
    .stop_enable_bit(stop_enable_bit),
    .debug_mode_enable_bit(debug_mode_enable_bit),
    .voltage_monitor_enable(voltage_monitor_enable),
    .voltage_monitor_stop_enable(voltage_monitor_stop_enable),
    .partial_powerdown_select(partial_powerdown_select),
    .stop_choice(stop_choice)
  );

  // wake and halt decodes
  assign any_wake = |wake_sync;
  assign deep_wake = wake_sync[`WAKE_BIT_RTC] && rtc_wake_enable;
  assign halt_cmd = cmd_valid && (cmd_class == `CMD_CLASS_ENTER_HALT);
  assign halt_event = halt_cmd || exec_halt_to_debug_instruction
      || serial_debug_controller_break || trace_module_break;

  // next state of the whole controller
  always_comb begin
    state_next = state_reg;
    state_next.clear_imask = 1'b0;
    state_next.stacking = 1'b0;
    state_next.illegal_rst = 1'b0;
    state_next.por_rst = 1'b0;
    state_next.fetch_rv = 1'b0;
    state_next.ans_valid = cmd_valid;
    state_next.ans_code = `ANS_ACCEPT;
    // command admission per mode
    case (state_reg.mode)
      MODE_RUN: begin
        if (cmd_class >= `CMD_CLASS_CPU_REG) begin
          state_next.ans_code = `ANS_REFUSED;
        end else begin
          state_next.ans_code = `ANS_ACCEPT;
        end
      end
      MODE_HALT: begin
        state_next.ans_code = `ANS_ACCEPT;
      end
      MODE_WAIT, MODE_LIGHT_STOP: begin
        if (cmd_class == `CMD_CLASS_MEM_STATUS) begin
          state_next.ans_code = `ANS_STOP_WAIT_ERROR;
        end else if (halt_cmd && (state_reg.mode == MODE_WAIT || state_reg.debug_clk)) begin
          state_next.ans_code = `ANS_ACCEPT;
        end else begin
          state_next.ans_code = `ANS_REFUSED;
        end
      end
      default: begin
        state_next.ans_valid = 1'b0;
      end
    endcase
    // mode transitions
    if (!state_reg.boot_done) begin
      state_next.boot_done = 1'b1;
      state_next.fetch_rv = ms_sync;
      state_next.mode = ms_sync ? MODE_RUN : MODE_HALT;
      state_next.cpu_run = ms_sync;
    end else begin
      case (state_reg.mode)
        MODE_RUN: begin
          if (halt_event) begin
            state_next.mode = MODE_HALT;
            state_next.cpu_run = 1'b0;
          end else if (exec_wait) begin
            state_next.mode = MODE_WAIT;
            state_next.cpu_clock_en = 1'b0;
            state_next.clear_imask = 1'b1;
          end else if (exec_stop) begin
            case (stop_choice)
              STOP_ILLEGAL: begin
                state_next.illegal_rst = 1'b1;
              end
              STOP_DEEP: begin
                state_next.mode = MODE_DEEP_STOP;
                state_next.core_pwr = 1'b0;
                state_next.lvr_en = 1'b0;
                state_next.regulator = 1'b0;
                state_next.debug_clk = 1'b0;
                state_next.latched = 1'b1;
                state_next.pins_held = pin_ctrl_live;
                state_next.cpu_clock_en = 1'b0;
              end
              default: begin
                state_next.mode = MODE_LIGHT_STOP;
                state_next.cpu_clock_en = 1'b0;
                state_next.debug_clk = debug_mode_enable_bit;
                state_next.regulator = debug_mode_enable_bit
                    || (stop_choice == STOP_LIGHT_REG);
              end
            endcase
          end
        end
        MODE_HALT: begin
          state_next.cpu_run = 1'b0;
          if (cmd_valid && cmd_class == `CMD_CLASS_RESUME) begin
            state_next.mode = MODE_RUN;
            state_next.cpu_run = 1'b1;
          end
        end
        MODE_WAIT: begin
          if (halt_cmd) begin
            state_next.mode = MODE_HALT;
            state_next.cpu_clock_en = 1'b1;
            state_next.cpu_run = 1'b0;
          end else if (any_wake) begin
            state_next.mode = MODE_RUN;
            state_next.cpu_clock_en = 1'b1;
            state_next.stacking = 1'b1;
          end
        end
        MODE_LIGHT_STOP: begin
          if (!rst_pin_sync_n) begin
            state_next.mode = MODE_RUN;
            state_next.fetch_rv = 1'b1;
            state_next.cpu_clock_en = 1'b1;
            state_next.regulator = 1'b1;
            state_next.debug_clk = 1'b1;
          end else if (halt_cmd && state_reg.debug_clk) begin
            state_next.mode = MODE_HALT;
            state_next.cpu_run = 1'b0;
            state_next.cpu_clock_en = 1'b1;
            state_next.regulator = 1'b1;
          end else if (any_wake) begin
            state_next.mode = MODE_RUN;
            state_next.stacking = 1'b1;
            state_next.cpu_clock_en = 1'b1;
            state_next.regulator = 1'b1;
            state_next.debug_clk = 1'b1;
          end
        end
        MODE_DEEP_STOP: begin
          if (!rst_pin_sync_n || deep_wake) begin
            state_next.mode = MODE_RUN;
            state_next.por_rst = 1'b1;
            state_next.fetch_rv = 1'b1;
            state_next.lvr_en = 1'b1;
            state_next.core_pwr = 1'b1;
            state_next.regulator = 1'b1;
            state_next.debug_clk = 1'b1;
            state_next.cpu_clock_en = 1'b1;
            state_next.cpu_run = 1'b1;
            state_next.ppd_flag = 1'b1;
          end
        end
        default: begin
          state_next.mode = MODE_RUN;
        end
      endcase
    end
    // acknowledge opens the pin latches; a new wake this cycle wins
    if (partial_powerdown_acknowledge && state_reg.mode != MODE_DEEP_STOP) begin
      state_next.ppd_flag = 1'b0;
      state_next.latched = 1'b0;
    end
    state_next.pins_out = state_next.latched ? state_next.pins_held : pin_ctrl_live;
  end

  // single register stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.mode <= MODE_HALT;
      state_reg.cpu_clock_en <= 1'b1;
      state_reg.debug_clk <= 1'b1;
      state_reg.regulator <= 1'b1;
      state_reg.core_pwr <= 1'b1;
      state_reg.lvr_en <= 1'b1;
      state_reg.pins_out <= PINS'(`PIN_RESET_VALUE);
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign mode = state_reg.mode;
  assign cpu_clock_en = state_reg.cpu_clock_en;
  assign cpu_run = state_reg.cpu_run;
  assign clear_interrupt_mask = state_reg.clear_imask;
  assign start_stacking = state_reg.stacking;
  assign illegal_opcode_reset = state_reg.illegal_rst;
  assign por_reset = state_reg.por_rst;
  assign fetch_reset_vector = state_reg.fetch_rv;
  assign debug_clock_en = state_reg.debug_clk;
  assign regulator_active = state_reg.regulator;
  assign core_power_en = state_reg.core_pwr;
  assign low_voltage_reset_en = state_reg.lvr_en;
  assign partial_powerdown_flag = state_reg.ppd_flag;
  assign pin_ctrl_out = state_reg.pins_out;
  assign ans_valid = state_reg.ans_valid;
  assign ans_code = state_reg.ans_code;

  // halt keeps cpu suspended
  AST_HALT_SUSPENDS: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MODE_HALT && $past(mode) == MODE_HALT) |-> !cpu_run)
    else $error("cpu running in halt");

  // stop disabled gives reset pulse, no mode change
  AST_STOP_ILLEGAL: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.boot_done && mode == MODE_RUN && !halt_event && !exec_wait && exec_stop
     && !stop_enable_bit) |=> (illegal_opcode_reset && mode == MODE_RUN))
    else $error("illegal stop not reset");

  // wait entry clears mask and stops cpu clock
  AST_WAIT_ENTRY: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MODE_WAIT && $past(mode) == MODE_RUN) |-> (clear_interrupt_mask && !cpu_clock_en))
    else $error("wait entry wrong");

  // run mode refuses the halt-only resume command
  AST_RUN_REFUSE: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg.boot_done && mode == MODE_RUN && cmd_valid && cmd_class == `CMD_CLASS_RESUME)
    |=> (ans_valid && ans_code == `ANS_REFUSED))
    else $error("halt-only command accepted in run");

  // status command in wait reports error
  AST_WAIT_STATUS: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MODE_WAIT && cmd_valid && cmd_class == `CMD_CLASS_MEM_STATUS)
    |=> ans_code == `ANS_STOP_WAIT_ERROR)
    else $error("status in wait not flagged");

  // deep stop latches pins and drops power
  AST_DEEP_ENTRY: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MODE_DEEP_STOP) |-> (!core_power_en && pin_ctrl_out == state_reg.pins_held))
    else $error("deep stop not latched");

  // deep wake acts as power-on reset and sets flag
  AST_DEEP_WAKE: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MODE_RUN && $past(mode) == MODE_DEEP_STOP)
    |-> (por_reset && fetch_reset_vector && partial_powerdown_flag && low_voltage_reset_en))
    else $error("deep wake incomplete");

  // flag holds until acknowledge
  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    (partial_powerdown_flag && !partial_powerdown_acknowledge) |=> partial_powerdown_flag)
    else $error("flag dropped without acknowledge");

  // debug-enabled light stop keeps debug clocks and regulator
  AST_LIGHT_DEBUG: assert property (@(posedge clock) disable iff (sys_rst)
    (mode == MODE_LIGHT_STOP && $past(mode) == MODE_RUN && $past(debug_mode_enable_bit))
    |-> (debug_clock_en && regulator_active))
    else $error("debug clocks dropped in stop");

endmodule : power_mode_controller
`default_nettype wire

// file: verification/debug_host.sv
`timescale 1ns/1ps
`default_nettype none
// debug host on the command port: one command, then the answer
module debug_host (
  input wire logic clock,
  input wire logic ans_valid,
  input wire logic [1:0] ans_code,
  output logic cmd_valid,
  output logic [2:0] cmd_class
);
  // link idles with no command pending
  initial begin
    cmd_valid = 1'b0;
    cmd_class = 3'h0;
  end

  // class is held through the taking edge, then scrambled once released
  task send(input logic [2:0] cls, output logic got, output logic [1:0] code);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_class <= cls;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_class <= ~cls;
    #1;
    got = ans_valid;
    code = ans_code;
  endtask : send
endmodule : debug_host
`default_nettype wire

// file: verification/tb_power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"
module tb_power_mode_controller
  import power_mode_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ms_pin = 1'b1;
  logic reset_pin_n = 1'b1;
  logic rtc_en = 1'b1;
  logic ack = 1'b0;
  logic [15:0] wake = 16'h0000;
  logic [4:0] cfg = 5'h00;
  logic [4:0] ev = 5'h00;
  logic [7:0] live = 8'h00;
  logic [4:0] seen = 5'h00;
  op_mode_t mode;
  logic cpu_clk, cpu_run, clr_mask, stacking, illegal, por, fetch, dbg_clk, reg_act;
  logic core_pwr, lvr_en, flag, ans_valid, cmd_valid;
  logic [7:0] pins;
  logic [1:0] ans_code;
  logic [2:0] cmd_class;
  int n_fail = 0;
  int tests_run = 0;

  always #12.5 clock = ~clock;

  // remembers every pulse output seen since the last clear
  always @(posedge clock) seen <= seen | {por, illegal, fetch, stacking, clr_mask};

  power_mode_controller i_dut (
    .clock(clock), .sys_rst(sys_rst), .mode_select_debug_pin(ms_pin),
    .reset_pin_n(reset_pin_n), .wake_irq(wake), .rtc_wake_enable(rtc_en),
    .stop_enable_bit(cfg[4]), .debug_mode_enable_bit(cfg[3]),
    .voltage_monitor_enable(cfg[2]), .voltage_monitor_stop_enable(cfg[1]),
    .partial_powerdown_select(cfg[0]), .partial_powerdown_acknowledge(ack),
    .exec_wait(ev[0]), .exec_stop(ev[1]), .exec_halt_to_debug_instruction(ev[2]),
    .serial_debug_controller_break(ev[3]), .trace_module_break(ev[4]),
    .cmd_valid(cmd_valid), .cmd_class(cmd_class), .pin_ctrl_live(live),
    .mode(mode), .cpu_clock_en(cpu_clk), .cpu_run(cpu_run),
    .clear_interrupt_mask(clr_mask), .start_stacking(stacking),
    .illegal_opcode_reset(illegal), .por_reset(por), .fetch_reset_vector(fetch),
    .debug_clock_en(dbg_clk), .regulator_active(reg_act), .core_power_en(core_pwr),
    .low_voltage_reset_en(lvr_en), .partial_powerdown_flag(flag), .pin_ctrl_out(pins),
    .ans_valid(ans_valid), .ans_code(ans_code)
  );

  debug_host i_host (
    .clock(clock), .ans_valid(ans_valid), .ans_code(ans_code),
    .cmd_valid(cmd_valid), .cmd_class(cmd_class)
  );

  task conclude;
    if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task chk_mode(input op_mode_t exp);
    chk("mode", {5'h00, exp}, {5'h00, mode});
  endtask : chk_mode

  task cycles(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cycles

  // bounded wait for a mode change caused by an asynchronous input
  task wait_mode(input op_mode_t m);
    for (int i = 0; i < 20 && mode !== m; i++) cycles(1);
    if (mode !== m) begin
      n_fail++;
      $display("ERROR wait mode expected %h seen %h", m, mode);
      conclude();
    end
  endtask : wait_mode

  task fire(input int idx);
    @(posedge clock);
    ev[idx] <= 1'b1;
    @(posedge clock);
    ev <= 5'h00;
    #1;
  endtask : fire

  task cmd(input logic [2:0] cls, input logic [1:0] exp);
    logic got;
    logic [1:0] code;
    i_host.send(cls, got, code);
    chk("ans_valid", 8'h01, {7'h00, got});
    chk("ans_code", {6'h00, exp}, {6'h00, code});
  endtask : cmd

  task boot(input logic pin);
    @(posedge clock);
    sys_rst <= 1'b1;
    ms_pin <= pin;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    cycles(1);
    seen = 5'h00;
  endtask : boot

  task stop_with(input logic [4:0] v);
    seen = 5'h00;
    @(posedge clock);
    cfg <= v;
    fire(1);
  endtask : stop_with

  task t_boot;
    boot(1'b0);
    chk_mode(MODE_HALT);
    chk("cpu_run", 8'h00, {7'h00, cpu_run});
    boot(1'b1);
    chk_mode(MODE_RUN);
    cycles(1);
    chk("fetch", 8'h01, {7'h00, seen[2]});
  endtask : t_boot

  task t_cmds;
    for (int c = 0; c < 3; c++) cmd(3'(c), `ANS_ACCEPT);
    for (int c = 4; c < 7; c++) cmd(3'(c), `ANS_REFUSED);
    chk_mode(MODE_RUN);
    cmd(3'h3, `ANS_ACCEPT);
    chk_mode(MODE_HALT);
    for (int c = 0; c < 6; c++) cmd(3'(c), `ANS_ACCEPT);
    chk_mode(MODE_HALT);
    cmd(3'h6, `ANS_ACCEPT);
    chk_mode(MODE_RUN);
    for (int k = 2; k < 5; k++) begin
      fire(k);
      chk_mode(MODE_HALT);
      cmd(3'h6, `ANS_ACCEPT);
    end
  endtask : t_cmds

  task t_wait;
    seen = 5'h00;
    fire(0);
    chk_mode(MODE_WAIT);
    chk("cpu_clk", 8'h00, {7'h00, cpu_clk});
    chk("clr_mask", 8'h01, {7'h00, clr_mask});
    cmd(3'h1, `ANS_STOP_WAIT_ERROR);
    cmd(3'h0, `ANS_REFUSED);
    @(posedge clock);
    wake[0] <= 1'b1;
    wait_mode(MODE_RUN);
    @(posedge clock);
    wake <= 16'h0000;
    cycles(1);
    chk("stacking", 8'h01, {7'h00, seen[1]});
    fire(0);
    cmd(3'h3, `ANS_ACCEPT);
    chk_mode(MODE_HALT);
    cmd(3'h6, `ANS_ACCEPT);
  endtask : t_wait

  task t_stop;
    stop_with(5'b00000);
    cycles(1);
    chk("illegal", 8'h01, {7'h00, seen[3]});
    chk_mode(MODE_RUN);
    stop_with(5'b11001);
    chk_mode(MODE_LIGHT_STOP);
    chk("dbg_clk", 8'h01, {7'h00, dbg_clk});
    chk("reg_act", 8'h01, {7'h00, reg_act});
    cmd(3'h1, `ANS_STOP_WAIT_ERROR);
    cmd(3'h3, `ANS_ACCEPT);
    chk_mode(MODE_HALT);
    cmd(3'h4, `ANS_ACCEPT);
    cmd(3'h6, `ANS_ACCEPT);
    stop_with(5'b10111);
    chk_mode(MODE_LIGHT_STOP);
    chk("reg_act", 8'h01, {7'h00, reg_act});
    cmd(3'h3, `ANS_REFUSED);
    chk_mode(MODE_LIGHT_STOP);
    @(posedge clock);
    wake[0] <= 1'b1;
    wait_mode(MODE_RUN);
    @(posedge clock);
    wake <= 16'h0000;
    stop_with(5'b10100);
    chk_mode(MODE_LIGHT_STOP);
    seen = 5'h00;
    @(posedge clock);
    reset_pin_n <= 1'b0;
    wait_mode(MODE_RUN);
    @(posedge clock);
    reset_pin_n <= 1'b1;
    cycles(1);
    chk("fetch", 8'h01, {7'h00, seen[2]});
  endtask : t_stop

  task t_deep;
    @(posedge clock);
    live <= 8'h5A;
    stop_with(5'b10101);
    chk_mode(MODE_DEEP_STOP);
    chk("core_pwr", 8'h00, {7'h00, core_pwr});
    chk("lvr_en", 8'h00, {7'h00, lvr_en});
    @(posedge clock);
    live <= 8'hA5;
    rtc_en <= 1'b0;
    wake <= 16'h1001;
    cycles(6);
    chk("pins", 8'h5A, pins);
    chk_mode(MODE_DEEP_STOP);
    @(posedge clock);
    rtc_en <= 1'b1;
    wake <= 16'h1000;
    wait_mode(MODE_RUN);
    @(posedge clock);
    wake <= 16'h0000;
    cycles(1);
    chk("por", 8'h01, {7'h00, seen[4]});
    chk("fetch", 8'h01, {7'h00, seen[2]});
    chk("lvr_en", 8'h01, {7'h00, lvr_en});
    chk("flag", 8'h01, {7'h00, flag});
    chk("pins", 8'h5A, pins);
    @(posedge clock);
    ack <= 1'b1;
    @(posedge clock);
    ack <= 1'b0;
    cycles(1);
    chk("flag", 8'h00, {7'h00, flag});
    chk("pins", 8'hA5, pins);
  endtask : t_deep

  // main sequence
  initial begin
    t_boot();
    t_cmds();
    t_wait();
    t_stop();
    t_deep();
    conclude();
  end
endmodule : tb_power_mode_controller
`default_nettype wire
